// ===== rtl/pmc_pad_cell.v
// drive and pull control for one port pin
// assumes direction and value already resolved by the caller
`timescale 1ns/10ps
module pmc_pad_cell (
  input wire pclk,
  input wire presetn,
  input wire is_output,
  input wire out_value,
  input wire open_drain,
  input wire pull_enable,
  input wire pull_polarity,
  output reg pad_out,
  output reg pad_oe,
  output reg pull_up,
  output reg pull_down
);
  reg pad_out_next;
  reg pad_oe_next;
  reg pull_up_next;
  reg pull_down_next;

  always @*
  begin
    // open drain drives only low, push-pull drives both levels
    pad_out_next = open_drain ? 1'b0 : out_value;
    pad_oe_next = is_output & (~open_drain | ~out_value);
    // pull-up on inputs and wired-or outputs only
    pull_up_next = pull_enable & ~pull_polarity & (~is_output | open_drain);
    // pull-down on inputs only
    pull_down_next = pull_enable & pull_polarity & ~is_output;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      pull_up <= 1'b0;
      pull_down <= 1'b0;
    end
    else
    begin
      pad_out <= pad_out_next;
      pad_oe <= pad_oe_next;
      pull_up <= pull_up_next;
      pull_down <= pull_down_next;
    end
  end
endmodule

// ===== rtl/pmc_port_m.v
// port m pad configuration: apb registers, peripheral muxing, pad control
// assumes spi and can controllers on pclk; pins asynchronous
//
// Operation
// - with polarity 0 and pull enabled, a pull-up is applied only while the pin is an input or a wired-or output.
// - with polarity 1 and pull enabled, a pull-down is applied only while the pin is an input.
// - with open-drain select 1, the output pin is only driven low and a high is left floating or pulled.
// - with open-drain select 0, the output pin is driven both high and low.
// - the open-drain select has no effect on a pin used as input.
// - polarity and open-drain fields are six bits, one per pin five down to zero.
// - pin five is general purpose or the spi serial clock.
// - pin four is general purpose or mosi, output as spi master and input as slave.
// - pin two is general purpose or miso, input as spi master and output as slave.
// - pin three is general purpose or the active-low spi slave select.
// - pin one is general purpose or the can transmit output when can is present.
// - pin zero is general purpose or the can receive input when can is present.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`include "pmc_consts.vh"
module pmc_port_m #(
  parameter CAN_PRESENT = 1
)(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [5:0] port_m_pin_in,
  output wire [5:0] port_m_pin_out,
  output wire [5:0] port_m_pin_oe,
  output wire [5:0] port_m_pull_up,
  output wire [5:0] port_m_pull_down,
  input wire spi_enable,
  input wire spi_master,
  input wire spi_ss_drive,
  input wire spi_sck_out,
  input wire spi_mosi_out,
  input wire spi_miso_out,
  input wire spi_ss_n_out,
  output wire spi_sck_in,
  output wire spi_mosi_in,
  output wire spi_miso_in,
  output wire spi_ss_n_in,
  input wire can_enable,
  input wire can_tx,
  output wire can_rx
);
  localparam W = `PMC_PIN_COUNT;

  // configuration registers
  reg [W-1:0] data_reg;
  reg [W-1:0] dir_reg;
  reg [W-1:0] pull_en_reg;
  reg [W-1:0] port_m_pull_polarity_reg;
  reg [W-1:0] port_m_open_drain_select_reg;
  reg [31:0] prdata_next;

  wire [W-1:0] pin_sync;
  wire [7:0] word_index;
  wire idx_data;
  wire idx_input;
  wire idx_dir;
  wire idx_pull_en;
  wire idx_pull_pol;
  wire idx_open_drain;
  wire mapped;
  wire aligned;
  wire wr_en;
  wire rd_setup;

  // resolved per-pin ownership
  reg [W-1:0] is_output;
  reg [W-1:0] out_value;
  wire spi_owns_ss;
  wire can_owns;

  pmc_sync #(
    .WIDTH(W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(port_m_pin_in),
    .sync_out(pin_sync)
  );

  // apb decode
  assign word_index = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h000000);
  assign idx_data = aligned && (word_index == `PMC_IDX_DATA);
  assign idx_input = aligned && (word_index == `PMC_IDX_INPUT);
  assign idx_dir = aligned && (word_index == `PMC_IDX_DIR);
  assign idx_pull_en = aligned && (word_index == `PMC_IDX_PULL_EN);
  assign idx_pull_pol = aligned && (word_index == `PMC_IDX_PULL_POL);
  assign idx_open_drain = aligned && (word_index == `PMC_IDX_OPEN_DRAIN);
  assign mapped = idx_data | idx_input | idx_dir | idx_pull_en | idx_pull_pol | idx_open_drain;

  // zero wait states, error on unmapped access
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_reg <= `PMC_RST_DATA;
      dir_reg <= `PMC_RST_DIR;
      pull_en_reg <= `PMC_RST_PULL_EN;
      port_m_pull_polarity_reg <= `PMC_RST_PULL_POL;
      port_m_open_drain_select_reg <= `PMC_RST_OPEN_DRAIN;
    end
    else if (wr_en)
    begin
      if (idx_data)
      begin
        data_reg <= pwdata[W-1:0];
      end
      if (idx_dir)
      begin
        dir_reg <= pwdata[W-1:0];
      end
      if (idx_pull_en)
      begin
        pull_en_reg <= pwdata[W-1:0];
      end
      if (idx_pull_pol)
      begin
        port_m_pull_polarity_reg <= pwdata[W-1:0];
      end
      if (idx_open_drain)
      begin
        port_m_open_drain_select_reg <= pwdata[W-1:0];
      end
    end
  end

  // read data prepared in the setup phase
  always @*
  begin
    prdata_next = 32'h00000000;
    if (idx_data)
    begin
      prdata_next[W-1:0] = data_reg;
    end
    else if (idx_input)
    begin
      prdata_next[W-1:0] = pin_sync;
    end
    else if (idx_dir)
    begin
      prdata_next[W-1:0] = dir_reg;
    end
    else if (idx_pull_en)
    begin
      prdata_next[W-1:0] = pull_en_reg;
    end
    else if (idx_pull_pol)
    begin
      prdata_next[W-1:0] = port_m_pull_polarity_reg;
    end
    else if (idx_open_drain)
    begin
      prdata_next[W-1:0] = port_m_open_drain_select_reg;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (rd_setup)
    begin
      prdata <= prdata_next;
    end
  end

  // peripheral ownership
  assign spi_owns_ss = spi_enable & (~spi_master | spi_ss_drive);
  assign can_owns = (CAN_PRESENT != 0) & can_enable;

  always @*
  begin
    // general purpose default: direction and data registers
    is_output = dir_reg;
    out_value = data_reg;
    if (spi_enable)
    begin
      is_output[`PMC_PIN_SCK] = spi_master;
      out_value[`PMC_PIN_SCK] = spi_sck_out;
      is_output[`PMC_PIN_MOSI] = spi_master;
      out_value[`PMC_PIN_MOSI] = spi_mosi_out;
      is_output[`PMC_PIN_MISO] = ~spi_master;
      out_value[`PMC_PIN_MISO] = spi_miso_out;
    end
    if (spi_owns_ss)
    begin
      is_output[`PMC_PIN_SS] = spi_master;
      out_value[`PMC_PIN_SS] = spi_ss_n_out;
    end
    if (can_owns)
    begin
      is_output[`PMC_PIN_CAN_TX] = 1'b1;
      out_value[`PMC_PIN_CAN_TX] = can_tx;
      is_output[`PMC_PIN_CAN_RX] = 1'b0;
      out_value[`PMC_PIN_CAN_RX] = 1'b0;
    end
  end

  // pin levels to the peripherals
  assign spi_sck_in = pin_sync[`PMC_PIN_SCK];
  assign spi_mosi_in = pin_sync[`PMC_PIN_MOSI];
  assign spi_miso_in = pin_sync[`PMC_PIN_MISO];
  assign spi_ss_n_in = spi_owns_ss ? pin_sync[`PMC_PIN_SS] : 1'b1;
  assign can_rx = can_owns ? pin_sync[`PMC_PIN_CAN_RX] : 1'b1;

  // one pad cell per pin
  genvar p;
  generate
    for (p = 0; p < W; p = p + 1)
    begin : g_pad
      pmc_pad_cell u_pad (
        .pclk(pclk),
        .presetn(presetn),
        .is_output(is_output[p]),
        .out_value(out_value[p]),
        .open_drain(port_m_open_drain_select_reg[p]),
        .pull_enable(pull_en_reg[p]),
        .pull_polarity(port_m_pull_polarity_reg[p]),
        .pad_out(port_m_pin_out[p]),
        .pad_oe(port_m_pin_oe[p]),
        .pull_up(port_m_pull_up[p]),
        .pull_down(port_m_pull_down[p])
      );
    end
  endgenerate
endmodule

// ===== rtl/pmc_sync.v
// two flip-flop synchroniser, one per bit
// assumes inputs are asynchronous to pclk
`timescale 1ns/10ps
module pmc_sync #(
  parameter WIDTH = 6
)(
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg stage1_reg;
      reg stage2_reg;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end
        else
        begin
          stage1_reg <= async_in[i];
          stage2_reg <= stage1_reg;
        end
      end
      assign sync_out[i] = stage2_reg;
    end
  endgenerate
endmodule

// ===== shared/pmc_consts.vh
// constants for the port m pad configuration block
// assumes 32-bit apb data, word aligned registers
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

`define PMC_PIN_COUNT 6
`define PMC_ADDR_WIDTH 8

// register indices, byte address is four times the index
`define PMC_IDX_DATA 8'h10
`define PMC_IDX_INPUT 8'h11
`define PMC_IDX_DIR 8'h12
`define PMC_IDX_PULL_EN 8'h14
`define PMC_IDX_PULL_POL 8'h15
`define PMC_IDX_OPEN_DRAIN 8'h16

// reset values
`define PMC_RST_DATA 6'h00
`define PMC_RST_DIR 6'h00
`define PMC_RST_PULL_EN 6'h00
`define PMC_RST_PULL_POL 6'h00
`define PMC_RST_OPEN_DRAIN 6'h00

// pin positions
`define PMC_PIN_SCK 5
`define PMC_PIN_MOSI 4
`define PMC_PIN_SS 3
`define PMC_PIN_MISO 2
`define PMC_PIN_CAN_TX 1
`define PMC_PIN_CAN_RX 0

`endif

// ===== test/pmc_ext_dev.sv
// external devices wired to the six port m pins
// assumes pad controls come straight from the port block
`timescale 1ns/10ps
module pmc_ext_dev (
  input wire [5:0] pad_out,
  input wire [5:0] pad_oe,
  input wire [5:0] pull_up,
  input wire [5:0] pull_down,
  input wire [5:0] ext_en,
  input wire [5:0] ext_val,
  output logic [5:0] pin_level
);
  // an undriven pin with no external drive and no pull shows the inverse of its current pad_out
  always_comb
    for (int i = 0; i < 6; i++)
      pin_level[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pull_up[i] | (~pull_down[i] & ~pad_out[i]);
endmodule

// ===== test/pmc_port_m_chk.sv
// assertions on the ports of pmc_port_m
// assumes one clock domain, bound into every pmc_port_m
`timescale 1ns/10ps
module pmc_port_m_chk #(
  parameter CAN_PRESENT = 1
)(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [5:0] port_m_pin_in,
  input wire [5:0] port_m_pin_out,
  input wire [5:0] port_m_pin_oe,
  input wire [5:0] port_m_pull_up,
  input wire [5:0] port_m_pull_down,
  input wire spi_enable,
  input wire spi_master,
  input wire spi_sck_out,
  input wire spi_miso_out,
  input wire spi_sck_in,
  input wire can_enable,
  input wire can_tx
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence up_three;
    presetn ##1 presetn ##1 presetn;
  endsequence
  no_pd_out_a: assert property ((port_m_pull_down & port_m_pin_oe) == 6'h00) else $error("pull-down on output");
  one_pull_a: assert property ((port_m_pull_up & port_m_pull_down) == 6'h00) else $error("both pulls on");
  no_od_high_a: assert property ((port_m_pull_up & port_m_pin_oe & port_m_pin_out) == 6'h00)
    else $error("high driven on wired-or pin");
  pready_high_a: assert property (pready) else $error("pready low");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  sck_drive_a: assert property ($past(presetn && spi_enable && spi_master && !spi_sck_out)
    |-> port_m_pin_oe[5] && !port_m_pin_out[5]) else $error("sck not driven");
  mosi_in_a: assert property ($past(presetn && spi_enable && !spi_master) |-> !port_m_pin_oe[4])
    else $error("mosi driven as slave");
  miso_drive_a: assert property ($past(presetn && spi_enable && !spi_master && !spi_miso_out)
    |-> port_m_pin_oe[2] && !port_m_pin_out[2]) else $error("miso not driven");
  can_tx_a: assert property ($past(presetn && CAN_PRESENT && can_enable && !can_tx)
    |-> port_m_pin_oe[1] && !port_m_pin_out[1]) else $error("can tx not driven");
  sck_sync_a: assert property (up_three |-> spi_sck_in == $past(port_m_pin_in[5], 2))
    else $error("sck input delay");
endmodule
bind pmc_port_m pmc_port_m_chk #(.CAN_PRESENT(CAN_PRESENT)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .port_m_pin_in(port_m_pin_in),
  .port_m_pin_out(port_m_pin_out), .port_m_pin_oe(port_m_pin_oe), .port_m_pull_up(port_m_pull_up),
  .port_m_pull_down(port_m_pull_down), .spi_enable(spi_enable), .spi_master(spi_master),
  .spi_sck_out(spi_sck_out), .spi_miso_out(spi_miso_out), .spi_sck_in(spi_sck_in),
  .can_enable(can_enable), .can_tx(can_tx));

// ===== test/port_m_pad_config_tb.sv
// testbench for pmc_port_m: apb register access and pad behaviour
// assumes pmc_ext_dev closes the pin loop
`timescale 1ns/10ps
`include "pmc_consts.vh"
module port_m_pad_config_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, q;
  logic [5:0] ext_en = 0, ext_val = 0;
  logic perr = 0;
  logic se = 0, sm = 0, ssd = 0, sck = 0, mosi = 0, miso = 0, ssn = 1, ce = 0, ctx = 1;
  wire [31:0] prdata;
  wire [5:0] pin, po, oe, pu, pd;
  wire pready, pslverr, sck_in, mosi_in, miso_in, ss_in, can_rx;
  int n_errors = 0, n_tests = 0;
  always #5 pclk = ~pclk;
  pmc_port_m dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_m_pin_in(pin), .port_m_pin_out(po), .port_m_pin_oe(oe), .port_m_pull_up(pu),
    .port_m_pull_down(pd), .spi_enable(se), .spi_master(sm), .spi_ss_drive(ssd), .spi_sck_out(sck),
    .spi_mosi_out(mosi), .spi_miso_out(miso), .spi_ss_n_out(ssn), .spi_sck_in(sck_in),
    .spi_mosi_in(mosi_in), .spi_miso_in(miso_in), .spi_ss_n_in(ss_in), .can_enable(ce), .can_tx(ctx),
    .can_rx(can_rx));
  pmc_ext_dev ext (.pad_out(po), .pad_oe(oe), .pull_up(pu), .pull_down(pd), .ext_en(ext_en),
    .ext_val(ext_val), .pin_level(pin));
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task ap(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] i, input logic [31:0] d);
    ap(1'b1, {22'h0, i, 2'b00}, d);
  endtask
  task rd(input logic [7:0] i);
    ap(1'b0, {22'h0, i, 2'b00}, 32'h0);
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task pads(input logic [5:0] e_oe, input logic [5:0] e_out);
    chk(32'(oe), 32'(e_oe));
    chk(32'(po), 32'(e_out));
  endtask
  task wrap_up;
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_errors++;
    wrap_up;
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rd(`PMC_IDX_PULL_POL);
    chk(q, 32'h0);
    chk(32'(perr), 32'h0);
    wr(`PMC_IDX_OPEN_DRAIN, 32'hffffffff);
    rd(`PMC_IDX_OPEN_DRAIN);
    chk(q, 32'h3f);
    ap(1'b1, 32'h3fc, 32'hff);
    chk(32'(perr), 32'h1);
    ap(1'b0, 32'h3fc, 32'h0);
    chk(q, 32'h0);
    chk(32'(perr), 32'h1);
    $display("registers done");
    wr(`PMC_IDX_OPEN_DRAIN, 32'h0);
    wr(`PMC_IDX_DIR, 32'h3f);
    wr(`PMC_IDX_DATA, 32'h15);
    wt(2);
    pads(6'h3f, 6'h15);
    rd(`PMC_IDX_INPUT);
    chk(q, 32'h15);
    wr(`PMC_IDX_OPEN_DRAIN, 32'h3f);
    wr(`PMC_IDX_PULL_EN, 32'h3f);
    wt(2);
    pads(6'h2a, 6'h00);
    chk(32'({pu, pd}), 32'hfc0);
    wr(`PMC_IDX_PULL_POL, 32'h3f);
    wt(2);
    chk(32'({pu, pd}), 32'h0);
    wr(`PMC_IDX_DIR, 32'h0);
    wt(2);
    pads(6'h00, 6'h00);
    chk(32'({pu, pd}), 32'h3f);
    wr(`PMC_IDX_OPEN_DRAIN, 32'h0);
    wr(`PMC_IDX_PULL_POL, 32'h0);
    wr(`PMC_IDX_DIR, 32'h3f);
    wt(2);
    chk(32'({pu, pd}), 32'h0);
    $display("pad drive done");
    wr(`PMC_IDX_DIR, 32'h0);
    wr(`PMC_IDX_PULL_EN, 32'h0);
    @(posedge pclk);
    se <= 1;
    sm <= 1;
    ssd <= 1;
    mosi <= 1;
    ssn <= 0;
    ext_en <= 6'h04;
    ext_val <= 6'h04;
    wt(3);
    pads(6'h38, 6'h11);
    chk(32'(miso_in), 32'h1);
    @(posedge pclk);
    sm <= 0;
    ext_en <= 6'h38;
    ext_val <= 6'h28;
    wt(3);
    pads(6'h04, 6'h11);
    chk(32'({sck_in, mosi_in, ss_in}), 32'h5);
    $display("spi done");
    @(posedge pclk);
    se <= 0;
    ce <= 1;
    ctx <= 0;
    ext_en <= 6'h01;
    ext_val <= 6'h00;
    wt(3);
    pads(6'h02, 6'h14);
    chk(32'(can_rx), 32'h0);
    @(posedge pclk);
    ce <= 0;
    wt(3);
    chk(32'({can_rx, ss_in}), 32'h3);
    $display("can done");
    wrap_up;
  end
endmodule
